/* pkg/svf_defs.svh */
// Constants for the subscriber variable filter.
// Summary of operation
// R1: Master loads network and variable identifiers per subscriber; both serve as match keys.
// R2: Each received frame is split into variables, each compared on its own.
// R3: A matching variable is forwarded to the cyclic process data output.
// R4: With the filter off, non-matching variables go to the mailbox output.
// R5: Bit 8 of the configuration word enables the filter; master writes 0x0100.
// R6: With the filter on, non-matching variables are dropped, nothing reaches the mailbox.
// R7: After initialisation the filter is off until the enable bit is set.
// R8: Master rewrites the enable setting at every start-up; enabling is recommended.
// R9: A match needs both identifiers equal within the same subscriber entry.
`ifndef SVF_DEFS_SVH
`define SVF_DEFS_SVH
`define SVF_CFG_FILTER_BIT   8
`define SVF_CFG_ENABLE_VALUE 16'h0100
`define SVF_CFG_RESET        16'h0000
`define SVF_NUM_SUBS         32
`define SVF_NETID_W          48
`define SVF_VARID_W          16
`define SVF_DATA_W           32
`define SVF_FIFO_DEPTH       8
`endif

/* pkg/svf_pkg.sv */
// Types shared by the subscriber variable filter.
package svf_pkg;
   // Destination chosen for one received variable.
   typedef enum logic [1:0] {SVF_DST_NONE, SVF_DST_PDO, SVF_DST_MBX, SVF_DST_DROP} svf_dst_t;
   // Receive parser states.
   typedef enum logic [1:0] {SVF_ST_HDR, SVF_ST_DATA, SVF_ST_SKIP} svf_state_t;
endpackage

/* rtl/svf_fifo.sv */
// Flip-flop FIFO with valid/ready handshakes on both sides.
`timescale 1ns/10ps
module svf_fifo
   import svf_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
)
(
   // Clock and reset.
   input  wire logic             mclk,
   input  wire logic             rstn,
   // Filling side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // Full and empty come from the count so they are never stale.
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage write.
   always_ff @(posedge mclk)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end

   // Pointers and occupancy.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* rtl/svf_filter.sv */
// Subscriber variable filter: splits frames into variables and routes each one.
`timescale 1ns/10ps
`include "svf_defs.svh"
module svf_filter
   import svf_pkg::*;
#(
   parameter int NSUB  = `SVF_NUM_SUBS,
   parameter int NETW  = `SVF_NETID_W,
   parameter int VARW  = `SVF_VARID_W,
   parameter int DW    = `SVF_DATA_W,
   parameter int DEPTH = `SVF_FIFO_DEPTH
)
(
   // Clock and reset.
   input  wire logic            mclk,
   input  wire logic            rstn,
   // Reinitialise pulse on entering operation.
   input  wire logic            reinit,
   // Configuration writes from the master.
   input  wire logic            cfg_wr,
   input  wire logic [15:0]     cfg_word,
   input  wire logic            sub_wr,
   input  wire logic [4:0]      sub_idx,
   input  wire logic [NETW-1:0] sub_net,
   input  wire logic [VARW-1:0] sub_var,
   input  wire logic            sub_en,
   // Received variable stream: header beat then data beats.
   input  wire logic            rx_valid,
   output logic                 rx_ready,
   input  wire logic            rx_hdr,
   input  wire logic            rx_last,
   input  wire logic [DW-1:0]   rx_data,
   input  wire logic [NETW-1:0] rx_net,
   input  wire logic [VARW-1:0] rx_var,
   // Cyclic process data output.
   output logic                 pdo_valid,
   output logic [DW-1:0]        pdo_data,
   output logic [4:0]           pdo_sub,
   output logic                 pdo_last,
   // Mailbox output.
   output logic                 mbx_valid,
   input  wire logic            mbx_ready,
   output logic [DW:0]          mbx_data,
   // Status.
   output logic                 filter_on,
   output logic [15:0]          drop_count
);
   logic [15:0]      cfg_q;
   logic [NETW-1:0]  net_q [NSUB];
   logic [VARW-1:0]  var_q [NSUB];
   logic [NSUB-1:0]  ena_q;
   logic [NSUB-1:0]  hit;
   svf_state_t       st_q;
   svf_dst_t         dst_q;
   logic [4:0]       sub_q;
   logic             hit_any;
   logic [4:0]       hit_idx;
   logic             take;
   logic             f_valid;
   logic             f_ready;
   logic [DW:0]      f_data;
   logic             pdo_valid_q;
   logic [DW-1:0]    pdo_data_q;
   logic [4:0]       pdo_sub_q;
   logic             pdo_last_q;
   logic             filter_on_q;
   logic [15:0]      drop_q;
   logic             mbx_valid_q;
   logic [DW:0]      mbx_data_q;

   // Configuration word; cleared on reinit so the filter starts off.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         cfg_q <= `SVF_CFG_RESET;                             // see R7
      else if (reinit)
         cfg_q <= `SVF_CFG_RESET;                             // see R7
      else if (cfg_wr)
         cfg_q <= cfg_word;                                   // see R5
   end

   // Subscriber table; one entry per subscriber, valid flag cleared on reinit.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         ena_q <= '0;
      else if (reinit)
         ena_q <= '0;
      else if (sub_wr)
         ena_q[sub_idx] <= sub_en;                            // see R1
   end

   // Identifier storage needs no reset since the valid flags gate it.
   always_ff @(posedge mclk)
   begin
      if (sub_wr)
      begin
         net_q[sub_idx] <= sub_net;                           // see R1
         var_q[sub_idx] <= sub_var;                           // see R1
      end
   end

   // Per-entry comparators; both identifiers must match in one entry.
   genvar gi;
   generate
      for (gi = 0; gi < NSUB; gi++)
      begin : g_cmp
         assign hit[gi] = ena_q[gi] && (net_q[gi] == rx_net)
                          && (var_q[gi] == rx_var);           // see R9
      end
   endgenerate

   // Lowest matching entry wins when several are configured alike.
   always_comb
   begin
      hit_any = 1'b0;
      hit_idx = '0;
      for (int i = NSUB - 1; i >= 0; i--)
      begin
         if (hit[i])
         begin
            hit_any = 1'b1;
            hit_idx = 5'(i);
         end
      end
   end

   // Mailbox beats stall the stream only when the FIFO is full.
   assign rx_ready = (st_q != SVF_ST_DATA) || (dst_q != SVF_DST_MBX) || f_ready;
   assign take     = rx_valid && rx_ready;
   assign f_valid  = rx_valid && (st_q == SVF_ST_DATA) && (dst_q == SVF_DST_MBX)
                     && !rx_hdr;
   assign f_data   = {rx_last, rx_data};

   // Parser: each header beat taken in the header state starts one variable, judged on its own.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q  <= SVF_ST_HDR;
         dst_q <= SVF_DST_NONE;
         sub_q <= '0;
      end
      else if (reinit)
      begin
         st_q  <= SVF_ST_HDR;
         dst_q <= SVF_DST_NONE;
      end
      else if (take)
      begin
         case (st_q)
            SVF_ST_HDR:
            begin
               if (rx_hdr)                                    // see R2
               begin
                  st_q  <= rx_last ? SVF_ST_HDR : SVF_ST_DATA;
                  sub_q <= hit_idx;
                  if (hit_any)
                     dst_q <= SVF_DST_PDO;                    // see R3
                  else if (cfg_q[`SVF_CFG_FILTER_BIT])
                     dst_q <= SVF_DST_DROP;                   // see R6
                  else
                     dst_q <= SVF_DST_MBX;                    // see R4
               end
            end
            SVF_ST_DATA:
            begin
               if (rx_last)
                  st_q <= SVF_ST_HDR;
            end
            default:
               st_q <= SVF_ST_HDR;
         endcase
      end
   end

   // Process data output registered from matching data beats.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         pdo_valid_q <= 1'b0;
         pdo_data_q  <= '0;
         pdo_sub_q   <= '0;
         pdo_last_q  <= 1'b0;
      end
      else
      begin
         pdo_valid_q <= take && (st_q == SVF_ST_DATA) && (dst_q == SVF_DST_PDO); // see R3
         pdo_data_q  <= rx_data;
         pdo_sub_q   <= sub_q;
         pdo_last_q  <= rx_last;
      end
   end

   // Count of dropped variables, for diagnosis.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         drop_q <= '0;
      else if (reinit)
         drop_q <= '0;
      else if (take && (st_q == SVF_ST_HDR) && rx_hdr && !hit_any
               && cfg_q[`SVF_CFG_FILTER_BIT])
         drop_q <= drop_q + 16'h0001;                         // see R6
   end

   // Mailbox FIFO absorbs bursts so the acyclic side can stall.
   logic             q_valid;
   logic [DW:0]      q_data;
   logic             q_pop;
   assign q_pop = q_valid && (!mbx_valid_q || mbx_ready);

   svf_fifo #(.WIDTH(DW + 1), .DEPTH(DEPTH)) u_fifo
   (
      .mclk      (mclk),
      .rstn      (rstn),
      .in_valid  (f_valid),
      .in_ready  (f_ready),
      .in_data   (f_data),
      .out_valid (q_valid),
      .out_ready (q_pop),
      .out_data  (q_data)
   );

   // Output register stage for the mailbox, holds until accepted.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         mbx_valid_q <= 1'b0;
         mbx_data_q  <= '0;
      end
      else if (!mbx_valid_q || mbx_ready)
      begin
         mbx_valid_q <= q_valid;                              // see R4
         mbx_data_q  <= q_data;
      end
   end

   // Filter state flag registered for the outside.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         filter_on_q <= 1'b0;
      else
         filter_on_q <= cfg_q[`SVF_CFG_FILTER_BIT];           // see R5
   end

   assign pdo_valid  = pdo_valid_q;
   assign pdo_data   = pdo_data_q;
   assign pdo_sub    = pdo_sub_q;
   assign pdo_last   = pdo_last_q;
   assign mbx_valid  = mbx_valid_q;
   assign mbx_data   = mbx_data_q;
   assign filter_on  = filter_on_q;
   assign drop_count = drop_q;

   // A matching data beat appears on the process data output next cycle.
   property p_pdo_fwd;
      @(posedge mclk) disable iff (!rstn)
      (take && st_q == SVF_ST_DATA && dst_q == SVF_DST_PDO) |=> pdo_valid;
   endproperty
   a_pdo_fwd: assert property (p_pdo_fwd) else $error("match not forwarded"); // see R3

   // A non-matching header with the filter on is marked dropped and queues nothing.
   property p_no_mbx_drop;
      @(posedge mclk) disable iff (!rstn)
      (take && st_q == SVF_ST_HDR && rx_hdr && !hit_any && cfg_q[`SVF_CFG_FILTER_BIT]
       && !reinit) |=> (dst_q == SVF_DST_DROP && !f_valid);
   endproperty
   a_no_mbx_drop: assert property (p_no_mbx_drop) else $error("dropped data queued"); // see R6

   // A non-matching header with filter off selects the mailbox.
   property p_mbx_sel;
      @(posedge mclk) disable iff (!rstn)
      (take && st_q == SVF_ST_HDR && rx_hdr && !hit_any && !cfg_q[`SVF_CFG_FILTER_BIT]
       && !reinit) |=> (dst_q == SVF_DST_MBX);
   endproperty
   a_mbx_sel: assert property (p_mbx_sel) else $error("mailbox not chosen"); // see R4

   // Reinit leaves the filter disabled.
   property p_reinit_off;
      @(posedge mclk) disable iff (!rstn)
      reinit |=> !cfg_q[`SVF_CFG_FILTER_BIT] ##1 !filter_on;
   endproperty
   a_reinit_off: assert property (p_reinit_off) else $error("filter on after reinit"); // see R7

   // Enable value turns the filter on, shown two cycles later.
   property p_enable;
      @(posedge mclk) disable iff (!rstn)
      (cfg_wr && !reinit && cfg_word == `SVF_CFG_ENABLE_VALUE) |=> ##1 filter_on;
   endproperty
   a_enable: assert property (p_enable) else $error("enable not seen"); // see R5

   // A match choice needs a valid entry with both identifiers equal.
   property p_match_both;
      @(posedge mclk) disable iff (!rstn)
      (take && st_q == SVF_ST_HDR && rx_hdr && hit_any) |->
      (net_q[hit_idx] == rx_net && var_q[hit_idx] == rx_var && ena_q[hit_idx]);
   endproperty
   a_match_both: assert property (p_match_both) else $error("partial match"); // see R9

   // A configured entry written and enabled is used for matching.
   property p_sub_load;
      @(posedge mclk) disable iff (!rstn)
      (sub_wr && sub_en && !reinit) |=> ena_q[$past(sub_idx)];
   endproperty
   a_sub_load: assert property (p_sub_load) else $error("entry not loaded"); // see R1

   // A header beat taken in the header state and not marked last moves the parser to the data state.
   property p_split;
      @(posedge mclk) disable iff (!rstn)
      (take && st_q == SVF_ST_HDR && rx_hdr && !rx_last && !reinit) |=> (st_q == SVF_ST_DATA);
   endproperty
   a_split: assert property (p_split) else $error("variable not split"); // see R2
endmodule

/* tb/svf_master_model.sv */
// Mailbox consumer standing on the master side of the filter.
`timescale 1ns/10ps
module svf_master_model
(
   // Clock and reset.
   input  wire logic mclk,
   input  wire logic rstn,
   // Mailbox handshake and a hold-off request from the bench.
   output logic      mbx_ready,
   input  wire logic stall
);
   logic [7:0] pat_q;

   // Ready follows a rotating pattern, so both prompt and slow takers are seen.
   always @(negedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         pat_q     <= 8'hB5;
         mbx_ready <= 1'b0;
      end
      else
      begin
         pat_q     <= {pat_q[6:0], pat_q[7]};
         mbx_ready <= !stall && pat_q[0];
      end
   end
endmodule

/* tb/tb.sv */
// Self-checking bench for the subscriber variable filter.
`timescale 1ns/10ps
module tb;
   logic        mclk = 0, rstn = 0, reinit = 0, cfg_wr = 0, sub_wr = 0, sub_en = 0, stall = 0;
   logic        rx_valid = 0, rx_hdr = 0, rx_last = 0;
   logic [15:0] cfg_word = 16'h0000, sub_var = 16'h0000, rx_var = 16'h0000;
   logic [4:0]  sub_idx = 5'h00;
   logic [47:0] sub_net = 48'h0, rx_net = 48'h0;
   logic [31:0] rx_data = 32'h0, seed = 32'h4AA1B19A;
   logic        rx_ready, pdo_valid, pdo_last, mbx_valid, mbx_ready, filter_on;
   logic [31:0] pdo_data;
   logic [4:0]  pdo_sub;
   logic [32:0] mbx_data;
   logic [15:0] drop_count;
   logic [47:0] t_net [32];
   logic [15:0] t_var [32];
   logic        t_en  [32] = '{default: 1'b0};
   logic [37:0] pdo_q [$];
   logic [32:0] mbx_q [$];
   logic        filt = 0, saw_full = 0;
   int          exp_drop = 0, err_count = 0, comparisons = 0;

   // Half-period toggle gives the 200 MHz clock.
   always #2.5 mclk = ~mclk;

   svf_filter svf_filter_inst (.mclk(mclk), .rstn(rstn), .reinit(reinit), .cfg_wr(cfg_wr),
      .cfg_word(cfg_word), .sub_wr(sub_wr), .sub_idx(sub_idx), .sub_net(sub_net),
      .sub_var(sub_var), .sub_en(sub_en), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_hdr(rx_hdr), .rx_last(rx_last), .rx_data(rx_data), .rx_net(rx_net),
      .rx_var(rx_var), .pdo_valid(pdo_valid), .pdo_data(pdo_data), .pdo_sub(pdo_sub),
      .pdo_last(pdo_last), .mbx_valid(mbx_valid), .mbx_ready(mbx_ready),
      .mbx_data(mbx_data), .filter_on(filter_on), .drop_count(drop_count));
   svf_master_model svf_master_model_inst (.mclk(mclk), .rstn(rstn), .mbx_ready(mbx_ready),
      .stall(stall));

   // Next value of the shift-register stream that feeds every random choice.
   function automatic logic [31:0] nxt();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   // Lowest enabled entry holding both identifiers, or -1.
   function automatic int find(input logic [47:0] n, input logic [15:0] v);
      for (int i = 0; i < 32; i++)
         if (t_en[i] && t_net[i] === n && t_var[i] === v)
            return i;
      return -1;
   endfunction

   task automatic miss(input string m);
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   task automatic cmp_pdo(input logic [37:0] got, input logic [37:0] exp);
      comparisons++;
      if (got !== exp) miss("process data word");
   endtask
   task automatic cmp_mbx(input logic [32:0] got, input logic [32:0] exp);
      comparisons++;
      if (got !== exp) miss("mailbox word");
   endtask
   task automatic cmp_stat(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) miss("status value");
   endtask

   // Both outputs are judged at the edge that takes them; an unexpected word is a fault.
   always @(posedge mclk)
   begin
      if (pdo_valid === 1'b1)
         if (pdo_q.size() == 0) miss("unexpected process data");
         else cmp_pdo({pdo_sub, pdo_last, pdo_data}, pdo_q.pop_front());
      if (mbx_valid === 1'b1 && mbx_ready === 1'b1)
         if (mbx_q.size() == 0) miss("unexpected mailbox word");
         else cmp_mbx(mbx_data, mbx_q.pop_front());
   end

   task automatic load(input int i, input logic [47:0] n, input logic [15:0] v);
      @(negedge mclk);
      {sub_wr, sub_idx, sub_net, sub_var, sub_en} = {1'b1, 5'(i), n, v, 1'b1};
      @(negedge mclk);
      sub_wr = 0;
      {t_net[i], t_var[i], t_en[i]} = {n, v, 1'b1};
   endtask

   // The old filter state stands for one cycle after the word is taken, then the new one.
   task automatic cfg(input logic [15:0] w);
      @(negedge mclk);
      {cfg_wr, cfg_word} = {1'b1, w};
      @(negedge mclk);
      cfg_wr = 0;
      cmp_stat(16'(filter_on), 16'(filt));
      filt = w[8];
      @(posedge mclk) #1 cmp_stat(16'(filter_on), 16'(filt));
   endtask

   // Header beat, then data beats; a full mailbox path holds the stream off.
   task automatic send_var(input logic [47:0] n, input logic [15:0] v, input int beats);
      int          s;
      logic [31:0] d;
      s = find(n, v);
      for (int b = 0; b <= beats; b++)
      begin
         d = nxt();
         @(negedge mclk);
         {rx_valid, rx_hdr, rx_last, rx_data, rx_net, rx_var} = {1'b1, b == 0, b == beats, d, n, v};
         #1;
         for (int k = 0; k < 500 && rx_ready !== 1'b1; k++)
         begin
            saw_full = 1;
            @(negedge mclk) #1;
         end
         @(posedge mclk);
         if (b > 0 && s >= 0) pdo_q.push_back({5'(s), rx_last, d});
         else if (b > 0 && !filt) mbx_q.push_back({rx_last, d});
      end
      if (s < 0 && filt) exp_drop++;
      @(negedge mclk);
      rx_valid = 0;
   endtask

   task automatic rand_phase(input int cnt);
      logic [31:0] r;
      int          k;
      for (int i = 0; i < cnt; i++)
      begin
         r = nxt();
         k = (r[2:1] == 2'h0) ? 0 : (r[2:1] == 2'h1) ? 5 : 31;
         if (r[0] && t_en[k]) send_var(t_net[k], t_var[k], 1 + r[4:3]);
         else send_var({nxt(), r[31:16]}, r[15:0], 1 + r[4:3]);
      end
   endtask

   task automatic wait_empty();
      for (int i = 0; i < 400 && (pdo_q.size() + mbx_q.size()) > 0; i++) @(posedge mclk);
      if (pdo_q.size() + mbx_q.size() > 0) miss("output words missing");
      @(negedge mclk);
   endtask

   task automatic wrap_up();
      if (err_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic setup();
      load(0, 48'hA0B1C2D3E4F5, 16'h1234);
      load(5, 48'h00112233AA55, 16'hBEEF);
      load(7, 48'h00112233AA55, 16'hBEEF);
      load(31, 48'hFFFFFFFFFFFF, 16'hFFFF);
   endtask

   // Main sequence.
   initial
   begin
      repeat (16) @(posedge mclk);
      @(negedge mclk) rstn = 1;
      @(posedge mclk) #1 cmp_stat(16'(filter_on), 16'h0000);
      setup();
      send_var(48'hA0B1C2D3E4F5, 16'h1234, 3);
      send_var(48'h00112233AA55, 16'h1234, 1);
      send_var(48'h00112233AA55, 16'hBEEF, 2);
      send_var(48'hFFFFFFFFFFFF, 16'hFFFF, 0);
      rand_phase(12);
      wait_empty();
      stall = 1;
      fork
         send_var(48'h123456789ABC, 16'h0001, 14);
         begin
            repeat (60) @(negedge mclk);
            stall = 0;
         end
      join
      cmp_stat(16'(saw_full), 16'h0001);
      wait_empty();
      cfg(16'h0100);
      rand_phase(12);
      send_var(48'hA0B1C2D3E4F5, 16'h0000, 2);
      send_var(48'h00112233AA55, 16'h0000, 0);
      wait_empty();
      cmp_stat(drop_count, 16'(exp_drop));
      cfg(16'hFEFF);
      cfg(16'h0100);
      @(negedge mclk) reinit = 1;
      @(negedge mclk) reinit = 0;
      t_en = '{default: 1'b0};
      {filt, exp_drop} = 0;
      @(posedge mclk) #1 cmp_stat(16'(filter_on), 16'h0000);
      cmp_stat(drop_count, 16'h0000);
      send_var(48'hA0B1C2D3E4F5, 16'h1234, 2);
      wait_empty();
      setup();
      cfg(16'h0100);
      rand_phase(8);
      wait_empty();
      cmp_stat(drop_count, 16'(exp_drop));
      wrap_up();
   end

   // Watchdog: the whole sequence needs far fewer than 20000 cycles.
   initial
   begin
      #100000;
      err_count++;
      wrap_up();
   end
endmodule
